// ==== rtl/sfm_top.sv ====
// Safety function block: door-guard bypass, two-hand control and mode-selector check.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "sfm_regs.svh"
// Contract
// R1: In automatic mode the energy output comes on when the door is closed, in any order.
// R2: In automatic mode the energy output drops as soon as the door opens.
// R3: Both mode inputs equal is an error and the energy output stays off.
// R4: In set-up mode alone the energy output is on whatever the door does.
// R5: A clean switch between the two modes does not in itself drop the energy output.
// R6: The two-hand enable needs all four channels and the extra condition high.
// R7: Both buttons must be pressed within a fixed 0.45 s window or no enable is given.
// R8: Each button channel has a flag that holds its input state.
// R9: The extra condition input must be high for the two-hand enable.
// R10: Buttons are normally-open contacts; other wiring must be inverted by configuration.
// R11: Mode valid is high only when exactly one assigned selector input is high.
// R12: One to eight selector slots may be assigned; unassigned slots are ignored.
// R13: After the enable is lost, all four channels must go low before a new grant; the code re-grants at once when only the extra condition dropped.
// R14: Inputs are sampled once per clock and outputs follow from those samples.
module sfm_top #(
  parameter int unsigned SIMUL_CYCLES = `SFM_SIMUL_CYCLES
) (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]                awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]                araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // Field inputs
  input  wire sfm_pkg::sfm_bypass_in_t   bypass_pins,
  input  wire sfm_pkg::sfm_two_hand_in_t two_hand_pins,
  input  wire logic [7:0]                mode_inputs,
  // Safety outputs
  output logic                           energy_output,
  output logic                           two_hand_enable,
  output logic                           single_mode_valid,
  output logic [3:0]                     button_error_flag,
  // Interrupt
  output logic                           irq
);
  import sfm_pkg::*;

  localparam logic [24:0] SIMUL_LAST = 25'(SIMUL_CYCLES - 1);

  sfm_state_t s;
  sfm_state_t next_s;
  logic [3:0] btn;
  logic       all_high;
  logic       all_low;
  logic       supp;
  logic       mode_ok;
  logic       timeout;
  logic [3:0] ev;
  logic [3:0] clr;

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `SFM_ADDR_CTRL, `SFM_ADDR_MODE_CFG, `SFM_ADDR_STATUS,
      `SFM_ADDR_IRQ_STATUS, `SFM_ADDR_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a, input sfm_state_t st,
                                            input logic sel_ok);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `SFM_ADDR_CTRL: w[3:0] = st.btn_invert;
      `SFM_ADDR_MODE_CFG: w[7:0] = st.mode_cfg;
      `SFM_ADDR_STATUS: begin
        w[`SFM_ST_ENERGY] = st.energy;
        w[`SFM_ST_TH_ENABLE] = st.th_enable;
        w[`SFM_ST_MODE_VALID] = sel_ok;
        w[`SFM_ST_MODE_ERR] = st.mode_err_q;
        w[`SFM_ST_FLAGS_LSB +: 4] = st.err_flags;
        w[`SFM_ST_FSM_LSB +: 3] = st.th_state;
      end
      `SFM_ADDR_IRQ_STATUS: w[3:0] = st.irq_status;
      `SFM_ADDR_IRQ_MASK: w[3:0] = st.irq_mask;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  always_comb begin
    next_s = s;
    clr = 4'h0;
    ev = 4'h0;
    timeout = 1'b0;

    // Write path: address and data are taken in either order, the write lands once both are in.
    if (awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.waddr = awaddr;
      next_s.awready = 1'b0;
    end
    if (wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata[7:0];
      next_s.wstrb0 = wstrb[0];
      next_s.wready = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.waddr) ? `SFM_RESP_OKAY : `SFM_RESP_SLVERR;
      // Every writable field sits in byte lane 0, so only that strobe matters.
      if (s.wstrb0) begin
        case (s.waddr)
          `SFM_ADDR_CTRL: next_s.btn_invert = s.wdata[3:0]; // R10
          `SFM_ADDR_MODE_CFG: next_s.mode_cfg = s.wdata;
          `SFM_ADDR_IRQ_STATUS: clr = s.wdata[3:0];
          `SFM_ADDR_IRQ_MASK: next_s.irq_mask = s.wdata[3:0];
          default: clr = 4'h0;
        endcase
      end
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // Read path: one outstanding read, data latched at the address handshake.
    if (arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = read_word(araddr, s, single_mode_valid);
      next_s.rresp = mapped(araddr) ? `SFM_RESP_OKAY : `SFM_RESP_SLVERR;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // Door-guard bypass evaluated straight from this cycle's samples, so a clean mode
    // change moves from one true term to the other without a gap.
    mode_ok = bypass_pins.auto_mode ^ bypass_pins.setup_mode; // R3
    next_s.energy = (bypass_pins.auto_mode && !bypass_pins.setup_mode &&
                     bypass_pins.door_guard_input) || // R1 R2 R14
                    (bypass_pins.setup_mode && !bypass_pins.auto_mode); // R4 R5
    next_s.mode_err_q = !mode_ok;

    // Two-hand control. Inversion lets NC or complementary contacts be wired.
    btn = {two_hand_pins.button_a_channel1, two_hand_pins.button_a_channel2,
           two_hand_pins.button_b_channel1, two_hand_pins.button_b_channel2} ^ s.btn_invert;
    supp = two_hand_pins.supplementary_condition;
    all_high = &btn;
    all_low = ~|btn;
    next_s.err_flags = btn; // R8
    case (s.th_state)
      SFM_TH_WAIT_LOW: begin
        if (all_low) begin
          next_s.th_state = SFM_TH_ARMED; // R13
        end
      end
      SFM_TH_ARMED: begin
        next_s.th_cnt = 25'h0000000;
        if (all_high) begin
          next_s.th_state = SFM_TH_ON;
        end else if (!all_low) begin
          next_s.th_state = SFM_TH_TIMING;
        end
      end
      SFM_TH_TIMING: begin
        if (all_high) begin
          next_s.th_state = SFM_TH_ON;
        end else if (all_low) begin
          next_s.th_state = SFM_TH_ARMED;
        end else if (s.th_cnt == SIMUL_LAST) begin
          // The window is measured from the first channel that went high.
          timeout = 1'b1;
          next_s.th_state = SFM_TH_LOCKED; // R7
        end else begin
          next_s.th_cnt = s.th_cnt + 25'h0000001;
        end
      end
      SFM_TH_ON: begin
        if (!all_high) begin
          next_s.th_state = SFM_TH_LOCKED; // R13
        end
      end
      SFM_TH_LOCKED: begin
        if (all_low) begin
          next_s.th_state = SFM_TH_ARMED; // R13
        end
      end
      default: next_s.th_state = SFM_TH_LOCKED;
    endcase
    next_s.th_enable = (next_s.th_state == SFM_TH_ON) && all_high && supp; // R6 R9

    // Sticky events; a set in the same cycle as a clear wins.
    ev[`SFM_EV_MODE_ERR] = !mode_ok && !s.mode_err_q;
    ev[`SFM_EV_TIMEOUT] = timeout;
    ev[`SFM_EV_TH_GRANT] = next_s.th_enable && !s.th_enable;
    ev[`SFM_EV_SEL_LOST] = s.sel_valid_q && !single_mode_valid;
    next_s.sel_valid_q = single_mode_valid;
    next_s.irq_status = (s.irq_status & ~clr) | ev;
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.btn_invert <= `SFM_CTRL_RESET;
      s.mode_cfg <= `SFM_MODE_CFG_RESET;
      s.irq_mask <= `SFM_IRQ_MASK_RESET;
    end else begin
      s <= next_s;
    end
  end

  sfm_mode_check u_mode_check (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .mode_inputs       (mode_inputs),
    .slot_cfg          (s.mode_cfg),
    .single_mode_valid (single_mode_valid)
  );

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign energy_output = s.energy;
  assign two_hand_enable = s.th_enable;
  assign button_error_flag = s.err_flags;
  assign irq = s.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_auto_run;
    bypass_pins.auto_mode && !bypass_pins.setup_mode && bypass_pins.door_guard_input;
  endsequence

  sequence s_to_setup;
    bypass_pins.setup_mode && !bypass_pins.auto_mode;
  endsequence

  property p_energy_auto;
    s_auto_run |=> energy_output;
  endproperty

  property p_energy_door_open;
    bypass_pins.auto_mode && !bypass_pins.door_guard_input |=> !energy_output;
  endproperty

  property p_mode_error;
    bypass_pins.auto_mode == bypass_pins.setup_mode |=> !energy_output;
  endproperty

  property p_setup_energy;
    s_to_setup |=> energy_output;
  endproperty

  property p_switch_keeps;
    s_auto_run ##1 s_to_setup |=> energy_output && $past(energy_output);
  endproperty

  property p_th_all_high;
    two_hand_enable |-> $past(all_high) && $past(supp);
  endproperty

  property p_window_expiry;
    s.th_state == SFM_TH_TIMING && s.th_cnt == SIMUL_LAST && !all_high && !all_low
      |=> s.th_state == SFM_TH_LOCKED && !two_hand_enable;
  endproperty

  property p_flags_follow;
    1'b1 |=> button_error_flag == $past(btn);
  endproperty

  property p_supp_gate;
    !supp |=> !two_hand_enable;
  endproperty

  sequence s_locked_held;
    s.th_state == SFM_TH_LOCKED && !all_low;
  endsequence

  property p_regrant_low;
    s_locked_held |=> !two_hand_enable;
  endproperty

  a_energy_auto: assert property (p_energy_auto) // R1
    else $error("Energy missing with door closed in auto mode.");
  a_energy_door_open: assert property (p_energy_door_open) // R2
    else $error("Energy still on after door opened in auto mode.");
  a_mode_error: assert property (p_mode_error) // R3
    else $error("Energy on with both mode inputs equal.");
  a_setup_energy: assert property (p_setup_energy) // R4
    else $error("Energy missing in set-up mode.");
  a_switch_keeps: assert property (p_switch_keeps) // R5
    else $error("Energy dropped on a clean mode change.");
  a_th_all_high: assert property (p_th_all_high) // R6
    else $error("Two-hand enable without all channels and condition high.");
  a_window_expiry: assert property (p_window_expiry) // R7
    else $error("Two-hand window expiry did not lock out the enable.");
  a_flags_follow: assert property (p_flags_follow) // R8
    else $error("Button flags do not hold the channel states.");
  a_supp_gate: assert property (p_supp_gate) // R9
    else $error("Two-hand enable with extra condition low.");
  a_regrant_low: assert property (p_regrant_low) // R13
    else $error("Two-hand enable granted before all channels went low.");

endmodule

// ==== shared/sfm_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the safety block.
`ifndef SFM_REGS_SVH
`define SFM_REGS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define SFM_ADDR_CTRL        8'h00
`define SFM_ADDR_MODE_CFG    8'h04
`define SFM_ADDR_STATUS      8'h08
`define SFM_ADDR_IRQ_STATUS  8'h0C
`define SFM_ADDR_IRQ_MASK    8'h10

// Reset values.
`define SFM_CTRL_RESET       4'h0
`define SFM_MODE_CFG_RESET   8'hFF
`define SFM_IRQ_MASK_RESET   4'h0

// Status register field positions.
`define SFM_ST_ENERGY        0
`define SFM_ST_TH_ENABLE     1
`define SFM_ST_MODE_VALID    2
`define SFM_ST_MODE_ERR      3
`define SFM_ST_FLAGS_LSB     4
`define SFM_ST_FSM_LSB       8

// Interrupt event bit positions.
`define SFM_EV_MODE_ERR      0
`define SFM_EV_TIMEOUT       1
`define SFM_EV_TH_GRANT      2
`define SFM_EV_SEL_LOST      3

// Bus responses.
`define SFM_RESP_OKAY        2'h0
`define SFM_RESP_SLVERR      2'h2

// Timing: clock rate in Hz, window in ms, and the derived cycle count (rounded down).
`define SFM_CLK_HZ           32'h0262_5A00
`define SFM_SIMUL_TIME_MS    32'h0000_01C2
`define SFM_MS_PER_S         32'h0000_03E8
`define SFM_SIMUL_CYCLES     (`SFM_SIMUL_TIME_MS * (`SFM_CLK_HZ / `SFM_MS_PER_S))

`endif

// ==== shared/sfm_pkg.sv ====
// Types shared by the safety block modules.
package sfm_pkg;

  typedef enum logic [2:0] {
    SFM_TH_WAIT_LOW,
    SFM_TH_ARMED,
    SFM_TH_TIMING,
    SFM_TH_ON,
    SFM_TH_LOCKED
  } sfm_th_state_t;

  typedef struct packed {
    logic door_guard_input;
    logic auto_mode;
    logic setup_mode;
  } sfm_bypass_in_t;

  typedef struct packed {
    logic button_a_channel1;
    logic button_a_channel2;
    logic button_b_channel1;
    logic button_b_channel2;
    logic supplementary_condition;
  } sfm_two_hand_in_t;

  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    waddr;
    logic [7:0]    wdata;
    logic          wstrb0;
    logic [3:0]    btn_invert;
    logic [7:0]    mode_cfg;
    logic [3:0]    irq_status;
    logic [3:0]    irq_mask;
    logic          irq;
    sfm_th_state_t th_state;
    logic [24:0]   th_cnt;
    logic          energy;
    logic          th_enable;
    logic [3:0]    err_flags;
    logic          mode_err_q;
    logic          sel_valid_q;
  } sfm_state_t;

  typedef struct packed {
    logic valid;
  } sfm_chk_state_t;

endpackage

// ==== rtl/sfm_mode_check.sv ====
// Mode-selector validator: exactly one assigned input high.
`timescale 1ns/1ps
module sfm_mode_check (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Selector contacts and slot assignment
  input  wire logic [7:0] mode_inputs,
  input  wire logic [7:0] slot_cfg,
  // Result
  output logic            single_mode_valid
);
  import sfm_pkg::*;

  sfm_chk_state_t s;
  sfm_chk_state_t next_s;
  logic [7:0]     active;

  always_comb begin
    next_s = s;
    // Unassigned slots are masked out before the test.
    active = mode_inputs & slot_cfg; // R12
    // A non-zero word with no second bit set has exactly one bit high.
    next_s.valid = (active != 8'h00) && ((active & (active - 8'h01)) == 8'h00); // R11
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign single_mode_valid = s.valid;

  sequence s_one_assigned;
    $onehot(mode_inputs & slot_cfg);
  endsequence

  property p_one_valid;
    @(posedge aclk) disable iff (!aresetn)
      s_one_assigned |=> single_mode_valid;
  endproperty

  property p_not_one_invalid;
    @(posedge aclk) disable iff (!aresetn)
      !$onehot(mode_inputs & slot_cfg) |=> !single_mode_valid;
  endproperty

  a_one_valid: assert property (p_one_valid) // R11
    else $error("Single assigned input high but mode not valid.");
  a_not_one_invalid: assert property (p_not_one_invalid) // R12
    else $error("Mode valid without exactly one assigned input high.");

endmodule

// ==== tb/sfm_field_model.sv ====
// Field-side model: door switch, mode contacts, two-hand buttons and selector contacts.
`timescale 1ns/1ps
module sfm_field_model (
  // Clock
  input  wire logic             aclk,
  // Commands from the bench
  input  wire logic [2:0]       bypass_cmd,
  input  wire logic [3:0]       press,
  input  wire logic [3:0]       nc_wired,
  input  wire logic             supp_cmd,
  input  wire logic [7:0]       sel_cmd,
  // Contact levels seen by the block
  output sfm_pkg::sfm_bypass_in_t   bypass_pins,
  output sfm_pkg::sfm_two_hand_in_t two_hand_pins,
  output logic [7:0]            mode_inputs
);
  import sfm_pkg::*;

  // A closed-when-idle contact opens on a press, so its raw level is the inverse.
  always_ff @(posedge aclk) begin
    bypass_pins   <= bypass_cmd;
    two_hand_pins <= {press ^ nc_wired, supp_cmd};
    mode_inputs   <= sel_cmd;
  end
endmodule

// ==== tb/sfm_top_bench.sv ====
// Self-checking bench for the safety function block.
`timescale 1ns/1ps
`include "sfm_regs.svh"
module sfm_top_bench;
  import sfm_pkg::*;
  localparam int SIM = 20;
  logic             aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, supp;
  logic             awready, wready, bvalid, arready, rvalid, energy, th_en, mode_ok, irq;
  logic [7:0]       awaddr, araddr, mode_inputs, sel_cmd;
  logic [31:0]      wdata, rdata;
  logic [3:0]       wstrb, flags, press, nc_wired;
  logic [1:0]       bresp, rresp;
  logic [2:0]       byp_cmd;
  sfm_bypass_in_t   bypass_pins;
  sfm_two_hand_in_t two_hand_pins;
  int               error_cnt, compares;
  logic [7:0]       ra [5] = '{`SFM_ADDR_CTRL, `SFM_ADDR_MODE_CFG, `SFM_ADDR_IRQ_STATUS,
                               `SFM_ADDR_IRQ_MASK, 8'h14};
  logic [31:0]      rv [5] = '{32'h0, 32'hFF, 32'h0, 32'h0, 32'h0};
  logic [2:0]       bseq [12] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7,
                                  3'h4, 3'h6, 3'h2, 3'h6};
  logic [7:0]       sv [7] = '{8'h00, 8'h01, 8'h80, 8'h03, 8'hFF, 8'h31, 8'hF0};

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  sfm_top #(.SIMUL_CYCLES(SIM)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .bypass_pins(bypass_pins), .two_hand_pins(two_hand_pins), .mode_inputs(mode_inputs),
    .energy_output(energy), .two_hand_enable(th_en), .single_mode_valid(mode_ok),
    .button_error_flag(flags), .irq(irq));

  sfm_field_model model (
    .aclk(aclk), .bypass_cmd(byp_cmd), .press(press), .nc_wired(nc_wired),
    .supp_cmd(supp), .sel_cmd(sel_cmd), .bypass_pins(bypass_pins),
    .two_hand_pins(two_hand_pins), .mode_inputs(mode_inputs));

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (bvalid) break;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk_bit(bvalid, 1'b1);
    chk_word({30'h0, bresp}, {30'h0, er});
    // One edge between transfers, so a following call never re-raises bready in this step.
    cyc(1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (rvalid) break;
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk_bit(rvalid, 1'b1);
    chk_word(rdata, exp);
    chk_word({30'h0, rresp}, {30'h0, er});
    cyc(1);
  endtask

  // Contacts pass the model flop and the input flop, so allow four edges.
  task automatic hands(input logic [3:0] p);
    press <= p;
    cyc(4);
  endtask

  task automatic chk_th(input logic en, input logic [3:0] fl);
    chk_bit(th_en, en);
    chk_word({28'h0, flags}, {28'h0, fl});
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    // Field levels at release keep every output at its reset value on the first edges.
    byp_cmd = 3'h2;
    press = 4'h0;
    nc_wired = 4'h0;
    supp = 1'b1;
    sel_cmd = 8'h00;
    cyc(12);
    aresetn <= 1'b1;
    cyc(3);
    sel_cmd <= 8'h01;
    for (int i = 0; i < 5; i++) begin
      rd_chk(ra[i], rv[i], (i == 4) ? `SFM_RESP_SLVERR : `SFM_RESP_OKAY);
    end
    axi_wr(8'h14, 32'hFF, `SFM_RESP_SLVERR);
    $display("register test done");

    for (int i = 0; i < 12; i++) begin
      byp_cmd <= bseq[i];
      cyc(3);
      chk_bit(energy, (bseq[i][1] ^ bseq[i][0]) & (bseq[i][0] | bseq[i][2]));
    end
    // A clean mode change must not leave a single-cycle gap in the output.
    byp_cmd <= 3'h5;
    repeat (4) begin
      cyc(1);
      chk_bit(energy, 1'b1);
    end
    $display("bypass test done");

    hands(4'hC);
    cyc(5);
    hands(4'hF);
    chk_th(1'b1, 4'hF);
    axi_wr(`SFM_ADDR_STATUS, 32'h0, `SFM_RESP_OKAY);
    rd_chk(`SFM_ADDR_STATUS, 32'h3F7, `SFM_RESP_OKAY);
    supp <= 1'b0;
    cyc(4);
    chk_bit(th_en, 1'b0);
    supp <= 1'b1;
    cyc(4);
    chk_bit(th_en, 1'b1);
    hands(4'h7);
    chk_th(1'b0, 4'h7);
    hands(4'hF);
    chk_bit(th_en, 1'b0);
    hands(4'h0);
    hands(4'hF);
    chk_bit(th_en, 1'b1);
    for (int k = 0; k < 2; k++) begin
      hands(4'h0);
      press <= 4'h3;
      cyc(k ? 22 : 17);
      hands(4'hF);
      chk_bit(th_en, k == 0);
    end
    for (int k = 0; k < 4; k++) begin
      hands(4'h0);
      cyc(SIM + 2);
      hands(4'hF ^ (4'h1 << k));
      chk_th(1'b0, 4'hF ^ (4'h1 << k));
    end
    nc_wired <= 4'h5;
    axi_wr(`SFM_ADDR_CTRL, 32'h5, `SFM_RESP_OKAY);
    hands(4'h0);
    cyc(SIM + 2);
    hands(4'hF);
    chk_th(1'b1, 4'hF);
    rd_chk(`SFM_ADDR_CTRL, 32'h5, `SFM_RESP_OKAY);
    $display("two-hand test done");

    for (int k = 0; k < 7; k++) begin
      if (k == 5) axi_wr(`SFM_ADDR_MODE_CFG, 32'h0F, `SFM_RESP_OKAY);
      sel_cmd <= sv[k];
      cyc(3);
      chk_bit(mode_ok, $onehot(sv[k] & ((k < 5) ? 8'hFF : 8'h0F)));
    end
    $display("selector test done");

    rd_chk(`SFM_ADDR_IRQ_STATUS, 32'hF, `SFM_RESP_OKAY);
    chk_bit(irq, 1'b0);
    axi_wr(`SFM_ADDR_IRQ_MASK, 32'h4, `SFM_RESP_OKAY);
    cyc(2);
    chk_bit(irq, 1'b1);
    axi_wr(`SFM_ADDR_IRQ_STATUS, 32'hB, `SFM_RESP_OKAY);
    cyc(2);
    chk_bit(irq, 1'b1);
    rd_chk(`SFM_ADDR_IRQ_STATUS, 32'h4, `SFM_RESP_OKAY);
    axi_wr(`SFM_ADDR_IRQ_STATUS, 32'h4, `SFM_RESP_OKAY);
    cyc(2);
    chk_bit(irq, 1'b0);
    // A write with byte lane 0 disabled is answered but must leave the mask alone.
    wstrb <= 4'hE;
    axi_wr(`SFM_ADDR_IRQ_MASK, 32'h0, `SFM_RESP_OKAY);
    wstrb <= 4'hF;
    rd_chk(`SFM_ADDR_IRQ_MASK, 32'h4, `SFM_RESP_OKAY);
    $display("interrupt test done");
    print_verdict();
  end
endmodule
